// file: shared/pscs_pkg.sv
// pscs_pkg: constants for the pin strap configuration select block
package pscs_pkg;
  // axi4-lite register byte offsets
  localparam logic [7:0] PSCS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSCS_STAT_OFS = 8'h04;
  localparam logic [7:0] PSCS_CFG_OFS = 8'h08;
  // ctrl register fields
  localparam int PSCS_CTRL_PWR_BIT = 0;
  localparam int PSCS_CTRL_EDGE_BIT = 1;
  localparam int PSCS_CTRL_BUS_BIT = 2;
  localparam int PSCS_CTRL_DIFF_BIT = 3;
  localparam int PSCS_CTRL_DESKEW_BIT = 4;
  localparam int PSCS_CTRL_SENSE_BIT = 5;
  localparam logic [5:0] PSCS_CTRL_RST = 6'h00;
  // status register fields
  localparam int PSCS_STAT_SERIAL_BIT = 0;
  localparam int PSCS_STAT_HPD_BIT = 1;
  localparam int PSCS_STAT_RXDET_BIT = 2;
  localparam int PSCS_STAT_HPDEV_BIT = 3;
  // effective configuration fields
  localparam int PSCS_CFG_PWR_BIT = 0;
  localparam int PSCS_CFG_EDGE_BIT = 1;
  localparam int PSCS_CFG_BUS_BIT = 2;
  localparam int PSCS_CFG_DIFF_BIT = 3;
  localparam int PSCS_CFG_DESKEW_BIT = 4;
  localparam int PSCS_CFG_SENSE_BIT = 5;
  localparam logic [1:0] PSCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSCS_RESP_SLVERR = 2'h2;
  // clock mode chosen from straps
  typedef enum logic {
    PSCS_CLK_SINGLE = 1'b0,
    PSCS_CLK_DIFF = 1'b1
  } pscs_clk_mode_t;
endpackage : pscs_pkg

// file: rtl/pscs_sync.sv
// pscs_sync: two flop synchroniser for a bundle of levels
`timescale 1ns/1ns
module pscs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("pscs_sync width must be positive");
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : pscs_sync

// file: rtl/pscs_top.sv
// pscs_top: strap or serial configuration select and monitor sense
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module pscs_top
  import pscs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // pins
  input wire logic i_serial_if_select,
  input wire logic i_bus_width_strap,
  input wire logic i_clock_mode_strap,
  input wire logic i_edge_strap,
  input wire logic i_vref_low_swing,
  input wire logic i_power_down_n,
  input wire logic i_deskew_enable_pin,
  input wire logic i_rx_detect,
  // serial data pin, open drain
  output logic o_serial_data_out,
  output logic o_serial_data_oe_n,
  // monitor sense, open drain
  output logic o_monitor_sense_out,
  output logic o_monitor_sense_oe_n,
  // effective configuration
  output logic o_powered_up,
  output logic o_latch_rising,
  output logic o_bus_24bit,
  output logic o_clock_diff,
  output logic o_deskew_en,
  output logic o_serial_active,
  output logic o_serial_rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  initial begin
    if (ADDR_W < 4) $error("pscs_top address width too small");
    if (ADDR_W > 32) $error("pscs_top address width too large");
  end

  // synchronised pins
  logic [7:0] pins_raw;
  logic [7:0] pins;
  assign pins_raw = {i_serial_if_select, i_bus_width_strap,
    i_clock_mode_strap, i_edge_strap, i_vref_low_swing, i_power_down_n,
    i_deskew_enable_pin, i_rx_detect};

  pscs_sync #(
    .WIDTH(8)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  wire sel_s = pins[7];
  wire bus_s = pins[6];
  wire cmode_s = pins[5];
  wire edge_s = pins[4];
  wire vref_s = pins[3];
  wire pdn_s = pins[2];
  wire deskew_s = pins[1];
  wire rxdet_s = pins[0];

  // serial logic reset: raw select pin, asynchronous assert
  wire ser_arst_n = i_resetn & i_serial_if_select;
  logic ser_rst_q1;
  logic ser_rst_q2;
  always_ff @(posedge i_clk or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      ser_rst_q1 <= 1'b0;
      ser_rst_q2 <= 1'b0;
    end else begin
      ser_rst_q1 <= 1'b1;
      ser_rst_q2 <= ser_rst_q1;
    end
  end
  wire ser_on = ser_rst_q2 & sel_s;
  assign o_serial_rst_n = ser_rst_q2;
  assign o_serial_active = ser_on;

  // clock mode decode from straps
  function automatic pscs_clk_mode_t clk_mode(input logic mode_strap,
                                              input logic width_strap,
                                              input logic vref_low);
    clk_mode = (mode_strap && !width_strap && vref_low) ? PSCS_CLK_DIFF
      : PSCS_CLK_SINGLE;
  endfunction : clk_mode

  // register hit vector: bit0 ctrl, bit1 status, bit2 config
  function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit[0] = (addr == ADDR_W'(PSCS_CTRL_OFS));
    reg_hit[1] = (addr == ADDR_W'(PSCS_STAT_OFS));
    reg_hit[2] = (addr == ADDR_W'(PSCS_CFG_OFS));
  endfunction : reg_hit

  // serial registers, defaults on select reset
  logic [5:0] ctrl;
  logic hpd_prev;
  logic hpd_event;
  logic hpd_armed;

  // axi write channel
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire have_aw = aw_hold | aw_take;
  wire have_w = w_hold | w_take;
  wire [ADDR_W-1:0] wr_addr = aw_hold ? aw_addr : i_awaddr;
  wire [31:0] wr_data = w_hold ? w_data : i_wdata;
  wire [3:0] wr_strb = w_hold ? w_strb : i_wstrb;
  wire wr_fire = have_aw & have_w & ~o_bvalid;
  wire [2:0] wr_hit = reg_hit(wr_addr);
  wire wr_ctrl = wr_fire & wr_hit[0];
  wire wr_stat = wr_fire & wr_hit[1];
  wire wr_ok = wr_ctrl | wr_stat;
  wire ctrl_we = wr_ctrl & wr_strb[0] & ser_on;
  assign o_awready = ~aw_hold & ~o_bvalid;
  assign o_wready = ~w_hold & ~o_bvalid;

  // write address holding register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end else begin
      if (aw_take) aw_addr <= i_awaddr;
      aw_hold <= have_aw & ~wr_fire;
    end
  end

  // write data holding register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (w_take) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      w_hold <= have_w & ~wr_fire;
    end
  end

  // write response, one outstanding
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bvalid <= 1'b0;
      o_bresp <= PSCS_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_ok ? PSCS_RESP_OKAY : PSCS_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // control register, reset whenever select drops
  always_ff @(posedge i_clk or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      ctrl <= PSCS_CTRL_RST;
    end else if (ctrl_we) begin
      ctrl <= wr_data[5:0];
    end
  end

  // hot-plug change event: armed one cycle after enable, no false edge
  wire hpd_change = hpd_armed & (edge_s ^ hpd_prev);
  wire hpd_clear = wr_stat & wr_strb[0] & wr_data[PSCS_STAT_HPDEV_BIT];
  always_ff @(posedge i_clk or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      hpd_prev <= 1'b0;
      hpd_armed <= 1'b0;
      hpd_event <= 1'b0;
    end else begin
      hpd_prev <= edge_s;
      hpd_armed <= ser_on;
      // set wins over write-one clear
      if (hpd_change) hpd_event <= 1'b1;
      else if (hpd_clear) hpd_event <= 1'b0;
    end
  end

  // effective configuration selection
  wire pwr_up_eff = ser_on ? ctrl[PSCS_CTRL_PWR_BIT] : pdn_s;
  wire edge_eff = ser_on ? ctrl[PSCS_CTRL_EDGE_BIT] : edge_s;
  wire bus_eff = ser_on ? ctrl[PSCS_CTRL_BUS_BIT] : bus_s;
  wire diff_eff = ser_on ? ctrl[PSCS_CTRL_DIFF_BIT]
    : (clk_mode(cmode_s, bus_s, vref_s) == PSCS_CLK_DIFF);
  wire deskew_eff = ser_on ? ctrl[PSCS_CTRL_DESKEW_BIT] : deskew_s;
  // receiver detect halts in power-down, serial port stays alive
  wire rx_seen = rxdet_s & pwr_up_eff;
  wire sense_eff = ser_on ? ctrl[PSCS_CTRL_SENSE_BIT]
    : rx_seen;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_powered_up <= 1'b0;
      o_latch_rising <= 1'b0;
      o_bus_24bit <= 1'b0;
      o_clock_diff <= 1'b0;
      o_deskew_en <= 1'b0;
      o_monitor_sense_oe_n <= 1'b1;
    end else begin
      o_powered_up <= pwr_up_eff;
      o_latch_rising <= edge_eff;
      o_bus_24bit <= bus_eff;
      o_clock_diff <= diff_eff;
      o_deskew_en <= deskew_eff & pwr_up_eff;
      o_monitor_sense_oe_n <= sense_eff;
    end
  end
  // open drain: only ever drives low
  assign o_monitor_sense_out = 1'b0;
  // serial data pin: never driven; protocol engine not in this block
  assign o_serial_data_out = 1'b0;
  assign o_serial_data_oe_n = 1'b1;

  // axi read channel
  wire [31:0] stat_word = {28'h0000000, hpd_event, rxdet_s,
    ser_on ? edge_s : 1'b0, ser_on};
  wire [31:0] ctrl_word = {26'h0, ctrl};
  wire [31:0] cfg_word = {26'h0, ~o_monitor_sense_oe_n, o_deskew_en,
    o_clock_diff, o_bus_24bit, o_latch_rising, o_powered_up};
  wire [2:0] rd_hit = reg_hit(i_araddr);
  wire rd_ctrl = rd_hit[0];
  wire rd_stat = rd_hit[1];
  wire rd_cfg = rd_hit[2];
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_stat ? stat_word
    : rd_cfg ? cfg_word : 32'h0000_0000;
  wire rd_ok = rd_ctrl | rd_stat | rd_cfg;
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= PSCS_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_ok ? PSCS_RESP_OKAY : PSCS_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule : pscs_top

// file: dv/pscs_top_properties.sv
// pscs_top_properties: port assertions for pscs_top
`timescale 1ns/1ns
module pscs_top_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // pins
  input wire logic i_serial_if_select,
  input wire logic i_bus_width_strap,
  input wire logic i_clock_mode_strap,
  input wire logic i_edge_strap,
  input wire logic i_vref_low_swing,
  input wire logic i_power_down_n,
  // outputs
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_oe_n,
  input wire logic o_monitor_sense_out,
  input wire logic o_monitor_sense_oe_n,
  input wire logic o_powered_up,
  input wire logic o_latch_rising,
  input wire logic o_bus_24bit,
  input wire logic o_clock_diff,
  input wire logic o_serial_rst_n
);
  logic [2:0] age;
  logic ok;
  assign ok = (age == 3'h7);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // cycles spent in strap mode, saturating
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) age <= 3'h0;
    else if (i_serial_if_select) age <= 3'h0;
    else if (!ok) age <= age + 3'h1;
  end
  AST_DATA_OD: assert property (
    !o_serial_data_oe_n |-> !o_serial_data_out)
    else $error("data pin driven high");
  AST_SENSE_OD: assert property (
    !o_monitor_sense_oe_n |-> !o_monitor_sense_out)
    else $error("sense pin driven high");
  AST_SEL_RESET: assert property (
    !i_serial_if_select |-> !o_serial_rst_n)
    else $error("serial logic not in reset");
  AST_SEL_ACTIVE: assert property (
    $rose(i_serial_if_select) ##0 i_serial_if_select[*6]
      |-> o_serial_rst_n)
    else $error("serial logic not released");
  AST_EDGE: assert property (
    ok |-> o_latch_rising == $past(i_edge_strap, 3))
    else $error("latch edge wrong");
  AST_BUS: assert property (
    ok |-> o_bus_24bit == $past(i_bus_width_strap, 3))
    else $error("bus width wrong");
  AST_CLK: assert property (
    ok |-> o_clock_diff == ($past(i_clock_mode_strap, 3)
      && !$past(i_bus_width_strap, 3) && $past(i_vref_low_swing, 3)))
    else $error("clock mode wrong");
  AST_PD: assert property (
    ok |-> o_powered_up == $past(i_power_down_n, 3))
    else $error("power state wrong");
endmodule : pscs_top_properties
bind pscs_top pscs_top_properties u_props (.*);

// file: dv/pscs_strap_host.sv
// pscs_strap_host: controller side driving straps and receiver detect
`timescale 1ns/1ns
module pscs_strap_host #(
  parameter bit DC_COUPLED = 1'b1
) (
  // requested levels
  input wire logic [6:0] i_cfg,
  input wire logic i_rx_on,
  // pin levels
  output logic [6:0] o_pins,
  output logic o_rx
);
  // select and straps passed through as static levels
  assign o_pins = i_cfg;
  // detect only meaningful on a dc-coupled link
  assign o_rx = DC_COUPLED & i_rx_on;
endmodule : pscs_strap_host

// file: dv/test_pin_strap_config_select.sv
// test_pin_strap_config_select: strap and register bench
`timescale 1ns/1ns
module test_pin_strap_config_select;
  import pscs_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, rx_on = 1'b0;
  logic i_serial_if_select, i_bus_width_strap, i_clock_mode_strap;
  logic i_edge_strap, i_vref_low_swing, i_power_down_n;
  logic i_deskew_enable_pin, i_rx_detect, o_serial_data_out;
  logic o_serial_data_oe_n, o_monitor_sense_out, o_monitor_sense_oe_n;
  logic o_powered_up, o_latch_rising, o_bus_24bit, o_clock_diff;
  logic o_deskew_en, o_serial_active, o_serial_rst_n;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd, r;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rr, br;
  logic [6:0] cfg = 7'h02;
  logic [5:0] e6;
  integer seed = 32'h477D;
  int miscompares = 0;
  int num_checks = 0;
  always #5 i_clk = ~i_clk;
  pscs_top dut (.*);
  pscs_strap_host host (.i_cfg(cfg), .i_rx_on(rx_on), .o_rx(i_rx_detect),
    .o_pins({i_serial_if_select, i_bus_width_strap, i_clock_mode_strap,
      i_edge_strap, i_vref_low_swing, i_power_down_n, i_deskew_enable_pin}));
  function automatic logic [5:0] exp_cfg(input logic [6:0] p, input logic x);
    exp_cfg = {x & p[1], p[0] & p[1], p[4] & ~p[5] & p[2], p[5], p[3], p[1]};
  endfunction : exp_cfg
  task test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    bit ok;
    ok = 1'b0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      ok = o_bvalid;
      br = o_bresp;
    end
    i_bready <= 1'b0;
    if (!ok) begin
      miscompares++;
      test_done();
    end
    @(posedge i_clk);
  endtask : axw
  task axr(input logic [7:0] a);
    bit ok;
    ok = 1'b0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      ok = o_rvalid;
      rd = o_rdata;
      rr = o_rresp;
    end
    i_rready <= 1'b0;
    if (!ok) begin
      miscompares++;
      test_done();
    end
    @(posedge i_clk);
  endtask : axr
  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      cfg <= {1'b0, i[2], i[1], r[0], i[0], r[1] | i[3], r[2]};
      rx_on <= r[3];
      repeat (8) @(posedge i_clk);
      e6 = exp_cfg(cfg, rx_on);
      axr(PSCS_CFG_OFS);
      chk("cfg", {26'h0, ~e6[5], e6[4:0]}, rd);
      chk("sense", e6[5], o_monitor_sense_oe_n);
      chk("pins", e6[4:0], {o_deskew_en, o_clock_diff, o_bus_24bit,
        o_latch_rising, o_powered_up});
    end
    axw(PSCS_CTRL_OFS, 32'h3F);
    chk("bresp", PSCS_RESP_OKAY, br);
    axr(PSCS_CTRL_OFS);
    chk("ctrl_strap", 32'h0, rd);
    axw(8'h40, 32'h0);
    chk("bresp_unmapped", PSCS_RESP_SLVERR, br);
    axr(8'h40);
    chk("unmapped", {30'h0, PSCS_RESP_SLVERR}, {rd[29:0], rr});
    for (int v = 0; v < 2; v++) begin
      cfg <= {3'h4, v[0], 3'h0};
      repeat (8) @(posedge i_clk);
      axr(PSCS_STAT_OFS);
      chk("status", {28'h0, v[0], rx_on, v[0], 1'b1}, rd & 32'hF);
      chk("active", 1'b1, o_serial_active);
      chk("data_oe_n", 1'b1, o_serial_data_oe_n);
      axw(PSCS_CTRL_OFS, {26'h0, v[0], 5'h1F});
      repeat (8) @(posedge i_clk);
      chk("po1", v[0], o_monitor_sense_oe_n);
      axr(PSCS_CFG_OFS);
      chk("cfg_ser", {26'h0, ~v[0], 5'h1F}, rd);
    end
    axw(PSCS_STAT_OFS, 32'h8);
    axr(PSCS_STAT_OFS);
    chk("hpd_clear", {28'h0, 1'b0, rx_on, 2'h3}, rd & 32'hF);
    cfg <= 7'h08;
    repeat (2) @(posedge i_clk);
    cfg <= 7'h48;
    repeat (8) @(posedge i_clk);
    axr(PSCS_CTRL_OFS);
    chk("ctrl_rst", 32'h0, rd);
    chk("pd_rst", 1'b0, o_powered_up);
    test_done();
  end
endmodule : test_pin_strap_config_select
